//--- dtc_pkg.sv
package dtc_pkg;

    // register bus geometry
    localparam int ADDR_W = 3;
    localparam int DATA_W = 16;
    localparam int CNT_W = 8;

    // register offsets (word index on the plain register port)
    localparam logic [2:0] ADR_CLOCK_SELECT = 3'h0;
    localparam logic [2:0] ADR_MODE_CONTROL = 3'h1;
    localparam logic [2:0] ADR_OUTPUT_CONTROL = 3'h2;
    localparam logic [2:0] ADR_COMPARE_LOW = 3'h3;
    localparam logic [2:0] ADR_COMPARE_HIGH = 3'h4;
    localparam logic [2:0] ADR_COUNT = 3'h5;

    // mode control fields
    localparam int MODE_EN_LOW = 0;
    localparam int MODE_EN_HIGH = 1;
    localparam int MODE_CASCADE = 2;
    localparam logic [2:0] MODE_RESET = 3'h0;

    // output control fields
    localparam int OUT_EN_LOW = 0;
    localparam int OUT_EN_HIGH = 4;
    localparam logic [7:0] OUTCTL_RESET = 8'h00;

    // clock select fields: low nibble feeds the low channel
    localparam int SEL_W = 4;
    localparam int SEL_LOW_LSB = 0;
    localparam int SEL_HIGH_LSB = 4;
    localparam logic [7:0] CLKSEL_RESET = 8'h00;

    // clock select codes
    localparam logic [3:0] CODE_EXT_FALL = 4'h0;
    localparam logic [3:0] CODE_EXT_RISE = 4'h1;
    localparam logic [3:0] CODE_DIV_FIRST = 4'h6;
    localparam logic [3:0] CODE_DIV_LAST = 4'he;
    localparam logic [3:0] CODE_DIV_SLOWEST = 4'hf;
    // tick index = code minus this, for codes 6..14 (divide by 2..512)
    localparam logic [3:0] CODE_TO_TICK = 4'h5;
    // slowest code divides by 2048
    localparam logic [3:0] TICK_SLOWEST = 4'hb;

    // prescaler width covers the slowest division
    localparam int PRE_W = 11;

    localparam logic [7:0] CNT_ZERO = 8'h00;
    localparam logic [7:0] CNT_TOP = 8'hff;
    localparam logic [7:0] CNT_ONE = 8'h01;
    localparam logic [15:0] DATA_ZERO = 16'h0000;

endpackage

//--- dtc_prescale.sv
`timescale 1ns/1ps
`default_nettype none

module dtc_prescale (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    output logic [dtc_pkg::PRE_W:1] ticks
);

    logic [dtc_pkg::PRE_W-1:0] div_reg;

    // free-running divider; both channels share it so their
    // ticks stay phase aligned
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= '0;
        end else if (ce) begin
            div_reg <= div_reg + 1'b1;
        end
    end

    // a divide-by-2^k tick fires when the low k bits are all ones
    genvar k;
    generate
        for (k = 1; k <= dtc_pkg::PRE_W; k++) begin : g_tick
            assign ticks[k] = ce & (&div_reg[k-1:0]);
        end
    endgenerate

endmodule

`default_nettype wire

//--- dtc_clk_pick.sv
`timescale 1ns/1ps
`default_nettype none

module dtc_clk_pick (
    input wire logic [3:0] code,
    input wire logic [dtc_pkg::PRE_W:1] ticks,
    input wire logic extRise,
    input wire logic extFall,
    output logic pulse,
    output logic illegal
);

    logic [3:0] tickIdx;

    // decode of the four-bit select; prohibited codes never count
    always_comb begin
        tickIdx = code - dtc_pkg::CODE_TO_TICK;
        pulse = 1'b0;
        illegal = 1'b0;
        if (code == dtc_pkg::CODE_EXT_FALL) begin
            pulse = extFall;
        end else if (code == dtc_pkg::CODE_EXT_RISE) begin
            pulse = extRise;
        end else if (code >= dtc_pkg::CODE_DIV_FIRST &&
                     code <= dtc_pkg::CODE_DIV_LAST) begin
            pulse = ticks[tickIdx];
        end else if (code == dtc_pkg::CODE_DIV_SLOWEST) begin
            pulse = ticks[dtc_pkg::TICK_SLOWEST];
        end else begin
            illegal = 1'b1;
        end
    end

endmodule

`default_nettype wire

//--- dtc_timer.sv
// How it works
// - An enabled output pin (enable bit 0 low channel, bit 4 high) inverts on each compare match.
// - With cascade select (mode bit 2) set, the low counter overflow clocks the high counter.
// - In cascade the whole 16-bit counter uses the low channel clock select bits 0 to 3.
// - In cascade the low channel count enable (mode bit 0) starts and stops the 16-bit counter.
// - In 16-bit interval use a double match clears both counters and raises the high request.
// - Select codes 0000/0001 take external edges, 0110..1111 divide by 2..512 and 2048.
// - In 16-bit event use the chained counter steps on the chosen edge of input A.
// - In 16-bit event use a double match clears both counters and raises the high request.
// - In cascade a low compare match still raises the low request and toggles output A.
// - The square-wave half period follows the selected clock, from two main clocks up.
// - In separate mode each counter clears on its own match and raises its own request.
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module dtc_timer (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [dtc_pkg::ADDR_W-1:0] busAddr,
    input wire logic [dtc_pkg::DATA_W-1:0] busWdata,
    input wire logic busWr,
    input wire logic busRd,
    output logic [dtc_pkg::DATA_W-1:0] busRdata,
    input wire logic eventInputA,
    input wire logic eventInputB,
    output logic waveOutA,
    output logic waveOutB,
    output logic matchIrqLow,
    output logic matchIrqHigh,
    output logic clockSelectBad
);

    logic [7:0] clockSelect_reg;
    logic [2:0] modeControl_reg;
    logic [7:0] outputControl_reg;
    logic [7:0] compareLow_reg;
    logic [7:0] compareHigh_reg;
    logic [7:0] counterLow_reg;
    logic [7:0] counterHigh_reg;
    logic [dtc_pkg::DATA_W-1:0] rdata_reg;
    logic waveA_reg;
    logic waveB_reg;
    logic irqLow_reg;
    logic irqHigh_reg;
    logic [7:0] counterLow_next;
    logic [7:0] counterHigh_next;

    // pin synchronisers and edge history
    logic [1:0] syncA_reg;
    logic [1:0] syncB_reg;
    logic prevA_reg;
    logic prevB_reg;
    logic riseA;
    logic fallA;
    logic riseB;
    logic fallB;

    logic [dtc_pkg::PRE_W:1] ticks;
    logic pulseLow;
    logic pulseHigh;
    logic badLow;
    logic badHigh;

    logic cascade;
    logic runLow;
    logic runHigh;
    logic outEnLow;
    logic outEnHigh;
    logic stepLow;
    logic stepHigh;
    logic matchLow;
    logic matchHigh;
    logic hitLow;
    logic hitHigh;
    logic clearLow;
    logic clearHigh;
    logic overflow;

    // two flops on each pin before anything looks at it; the first
    // stage feeds only the second
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            syncA_reg <= 2'h0;
            syncB_reg <= 2'h0;
        end else if (ce) begin
            syncA_reg <= {syncA_reg[0], eventInputA};
            syncB_reg <= {syncB_reg[0], eventInputB};
        end
    end

    // edge history taken from the second stage only
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prevA_reg <= 1'b0;
            prevB_reg <= 1'b0;
        end else if (ce) begin
            prevA_reg <= syncA_reg[1];
            prevB_reg <= syncB_reg[1];
        end
    end

    // edges are only real while ce runs, so a frozen cycle is no event
    assign riseA = ce & syncA_reg[1] & ~prevA_reg;
    assign fallA = ce & ~syncA_reg[1] & prevA_reg;
    assign riseB = ce & syncB_reg[1] & ~prevB_reg;
    assign fallB = ce & ~syncB_reg[1] & prevB_reg;

    dtc_prescale u_prescale (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .ce(ce),
        .ticks(ticks)
    );

    // low channel clock: in cascade this one drives the whole chain
    dtc_clk_pick u_pick_low (
        .code(clockSelect_reg[dtc_pkg::SEL_LOW_LSB +: dtc_pkg::SEL_W]),
        .ticks(ticks),
        .extRise(riseA),
        .extFall(fallA),
        .pulse(pulseLow),
        .illegal(badLow)
    );

    // high channel clock, only used in separate mode
    dtc_clk_pick u_pick_high (
        .code(clockSelect_reg[dtc_pkg::SEL_HIGH_LSB +: dtc_pkg::SEL_W]),
        .ticks(ticks),
        .extRise(riseB),
        .extFall(fallB),
        .pulse(pulseHigh),
        .illegal(badHigh)
    );

    // mode decode
    assign cascade = modeControl_reg[dtc_pkg::MODE_CASCADE];
    assign runLow = modeControl_reg[dtc_pkg::MODE_EN_LOW];
    // cascade hands start/stop of the chain to the low enable
    assign runHigh = cascade ? runLow :
                     modeControl_reg[dtc_pkg::MODE_EN_HIGH];
    assign outEnLow = outputControl_reg[dtc_pkg::OUT_EN_LOW];
    assign outEnHigh = outputControl_reg[dtc_pkg::OUT_EN_HIGH];
    // high select is ignored in cascade, so only the used codes count
    assign clockSelectBad = badLow | (~cascade & badHigh);

    // match and step terms
    assign stepLow = runLow & pulseLow;
    assign matchLow = (counterLow_reg == compareLow_reg);
    assign matchHigh = (counterHigh_reg == compareHigh_reg);
    // low match is seen in both modes, on the low count clock
    assign hitLow = stepLow & matchLow;
    // in cascade the low half only clears when both halves match
    assign clearLow = cascade ? (hitLow & matchHigh) : hitLow;
    assign overflow = stepLow & (counterLow_reg == dtc_pkg::CNT_TOP) &
                      ~clearLow;
    // chain carry replaces the high channel's own clock
    assign stepHigh = cascade ? overflow : (runHigh & pulseHigh);
    assign hitHigh = cascade ? clearLow : (stepHigh & matchHigh);
    assign clearHigh = hitHigh;

    // next counter values; a stopped counter sits at zero so that a
    // restart always begins a full interval
    always_comb begin
        counterLow_next = counterLow_reg;
        if (!runLow) begin
            counterLow_next = dtc_pkg::CNT_ZERO;
        end else if (clearLow) begin
            counterLow_next = dtc_pkg::CNT_ZERO;
        end else if (stepLow) begin
            counterLow_next = counterLow_reg + dtc_pkg::CNT_ONE;
        end
    end

    always_comb begin
        counterHigh_next = counterHigh_reg;
        if (!runHigh) begin
            counterHigh_next = dtc_pkg::CNT_ZERO;
        end else if (clearHigh) begin
            counterHigh_next = dtc_pkg::CNT_ZERO;
        end else if (stepHigh) begin
            counterHigh_next = counterHigh_reg + dtc_pkg::CNT_ONE;
        end
    end

    // counters
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            counterLow_reg <= dtc_pkg::CNT_ZERO;
            counterHigh_reg <= dtc_pkg::CNT_ZERO;
        end else if (ce) begin
            counterLow_reg <= counterLow_next;
            counterHigh_reg <= counterHigh_next;
        end
    end

    // wave flip-flops; a disabled output just holds its level
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            waveA_reg <= 1'b0;
            waveB_reg <= 1'b0;
        end else if (ce) begin
            if (hitLow && outEnLow) begin
                waveA_reg <= ~waveA_reg;
            end
            if (hitHigh && outEnHigh) begin
                waveB_reg <= ~waveB_reg;
            end
        end
    end

    // request pulses, one cycle each
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irqLow_reg <= 1'b0;
            irqHigh_reg <= 1'b0;
        end else if (ce) begin
            irqLow_reg <= hitLow;
            irqHigh_reg <= hitHigh;
        end
    end

    // register writes; counters are read only
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            clockSelect_reg <= dtc_pkg::CLKSEL_RESET;
            modeControl_reg <= dtc_pkg::MODE_RESET;
            outputControl_reg <= dtc_pkg::OUTCTL_RESET;
            compareLow_reg <= dtc_pkg::CNT_ZERO;
            compareHigh_reg <= dtc_pkg::CNT_ZERO;
        end else if (ce && busWr) begin
            unique case (busAddr)
                dtc_pkg::ADR_CLOCK_SELECT: begin
                    clockSelect_reg <= busWdata[7:0];
                end
                dtc_pkg::ADR_MODE_CONTROL: begin
                    modeControl_reg <= busWdata[2:0];
                end
                dtc_pkg::ADR_OUTPUT_CONTROL: begin
                    outputControl_reg <= busWdata[7:0];
                end
                dtc_pkg::ADR_COMPARE_LOW: begin
                    compareLow_reg <= busWdata[7:0];
                end
                dtc_pkg::ADR_COMPARE_HIGH: begin
                    compareHigh_reg <= busWdata[7:0];
                end
                default: begin
                end
            endcase
        end
    end

    // read data stand for one cycle only; the count is taken whole in
    // a single cycle so the two halves can never tear
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= dtc_pkg::DATA_ZERO;
        end else if (ce) begin
            rdata_reg <= dtc_pkg::DATA_ZERO;
            if (busRd) begin
                unique case (busAddr)
                    dtc_pkg::ADR_CLOCK_SELECT: begin
                        rdata_reg <= {8'h00, clockSelect_reg};
                    end
                    dtc_pkg::ADR_MODE_CONTROL: begin
                        rdata_reg <= {13'h0000, modeControl_reg};
                    end
                    dtc_pkg::ADR_OUTPUT_CONTROL: begin
                        rdata_reg <= {8'h00, outputControl_reg};
                    end
                    dtc_pkg::ADR_COMPARE_LOW: begin
                        rdata_reg <= {8'h00, compareLow_reg};
                    end
                    dtc_pkg::ADR_COMPARE_HIGH: begin
                        rdata_reg <= {8'h00, compareHigh_reg};
                    end
                    dtc_pkg::ADR_COUNT: begin
                        rdata_reg <= {counterHigh_reg, counterLow_reg};
                    end
                    default: begin
                        rdata_reg <= dtc_pkg::DATA_ZERO;
                    end
                endcase
            end
        end
    end

    assign busRdata = rdata_reg;
    assign waveOutA = waveA_reg;
    assign waveOutB = waveB_reg;
    assign matchIrqLow = irqLow_reg;
    assign matchIrqHigh = irqHigh_reg;

    // checks on the counting core
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    chk_low_clear_sep: assert property (
        (ce && !cascade && hitLow) |=> counterLow_reg == dtc_pkg::CNT_ZERO
            && matchIrqLow)
        else $error("low counter did not clear on its match");

    chk_chain_clear: assert property (
        (ce && cascade && runLow && pulseLow && matchLow && matchHigh) |=>
            counterLow_reg == dtc_pkg::CNT_ZERO &&
            counterHigh_reg == dtc_pkg::CNT_ZERO && matchIrqHigh)
        else $error("chain did not clear on double match");

    chk_chain_low_irq: assert property (
        (ce && cascade && stepLow && matchLow && !matchHigh) |=>
            matchIrqLow && !matchIrqHigh &&
            counterLow_reg == $past(counterLow_reg) + dtc_pkg::CNT_ONE)
        else $error("partial match in cascade handled wrongly");

    chk_chain_carry: assert property (
        (ce && cascade && stepLow && !clearLow &&
         counterLow_reg == dtc_pkg::CNT_TOP) |=>
            counterHigh_reg == $past(counterHigh_reg) + dtc_pkg::CNT_ONE &&
            counterLow_reg == dtc_pkg::CNT_ZERO)
        else $error("low overflow did not carry into high");

    chk_chain_stop: assert property (
        (ce && cascade && !runLow) |=>
            counterLow_reg == dtc_pkg::CNT_ZERO &&
            counterHigh_reg == dtc_pkg::CNT_ZERO)
        else $error("stopped chain kept a count");

    chk_wave_toggle: assert property (
        (ce && hitLow && outEnLow) |=> waveOutA != $past(waveOutA))
        else $error("output A did not invert on match");

    chk_div2_rate: assert property (
        (ce && clockSelect_reg[3:0] == dtc_pkg::CODE_DIV_FIRST
         && pulseLow) |=> !pulseLow)
        else $error("fastest select ticks faster than two clocks");

    chk_edge_count: assert property (
        (ce && runLow && !clearLow &&
         clockSelect_reg[3:0] == dtc_pkg::CODE_EXT_RISE &&
         syncA_reg[1] && !prevA_reg) |=>
            counterLow_reg == $past(counterLow_reg) + dtc_pkg::CNT_ONE)
        else $error("rising edge on input A was not counted");

    chk_count_read: assert property (
        (ce && busRd && busAddr == dtc_pkg::ADR_COUNT) |=>
            busRdata == {$past(counterHigh_reg), $past(counterLow_reg)})
        else $error("count read lost its byte order");

endmodule

`default_nettype wire

//--- dtc_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none

module dtc_timer_tb;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [2:0] busAddr = 3'h0;
    logic [15:0] busWdata = 16'h0000;
    logic busWr = 1'b0;
    logic busRd = 1'b0;
    logic [15:0] busRdata;
    logic eventInputA = 1'b0;
    logic eventInputB = 1'b0;
    logic waveOutA;
    logic waveOutB;
    logic matchIrqLow;
    logic matchIrqHigh;
    logic clockSelectBad;
    int fails = 0;
    int cmpCount = 0;

    dtc_timer DUT (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .ce(ce),
        .busAddr(busAddr),
        .busWdata(busWdata),
        .busWr(busWr),
        .busRd(busRd),
        .busRdata(busRdata),
        .eventInputA(eventInputA),
        .eventInputB(eventInputB),
        .waveOutA(waveOutA),
        .waveOutB(waveOutB),
        .matchIrqLow(matchIrqLow),
        .matchIrqHigh(matchIrqHigh),
        .clockSelectBad(clockSelectBad)
    );

    // 100 ns main clock
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", cmpCount, fails);
        if (fails == 0 && cmpCount > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        cmpCount++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one-cycle write strobe, launched right after an edge
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        busWr <= 1'b1;
        busAddr <= a;
        busWdata <= d;
        @(posedge ref_clk);
        busWr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd_chk(input string what, input logic [2:0] a,
                          input logic [15:0] exp);
        @(posedge ref_clk);
        busRd <= 1'b1;
        busAddr <= a;
        @(posedge ref_clk);
        busRd <= 1'b0;
        @(negedge ref_clk);
        check(what, exp, busRdata);
    endtask

    // irq pulses last one cycle, so look once per negedge
    task automatic wait_pulse(input logic hi, input int limit, output int n);
        n = 0;
        while (n < limit) begin
            @(negedge ref_clk);
            n++;
            if ((hi ? matchIrqHigh : matchIrqLow) === 1'b1) begin
                break;
            end
        end
    endtask

    task automatic period(input logic hi, input int limit, output int p);
        int n;
        wait_pulse(hi, limit, n);
        wait_pulse(hi, limit, p);
    endtask

    // slow pulses so the two-flop synchroniser sees every edge
    task automatic pulses(input int k);
        for (int i = 0; i < k; i++) begin
            @(posedge ref_clk);
            eventInputA <= 1'b1;
            repeat (4) @(posedge ref_clk);
            eventInputA <= 1'b0;
            repeat (4) @(posedge ref_clk);
        end
    endtask

    task automatic t_regs;
        for (int i = 0; i < 6; i++) begin
            rd_chk("reset value", 3'(i), 16'h0000);
        end
        wr(dtc_pkg::ADR_CLOCK_SELECT, 16'hffa7);
        rd_chk("clock select", dtc_pkg::ADR_CLOCK_SELECT, 16'h00a7);
        @(negedge ref_clk);
        check("read data after its cycle", 16'h0000, busRdata);
        wr(dtc_pkg::ADR_OUTPUT_CONTROL, 16'h0011);
        rd_chk("output control", dtc_pkg::ADR_OUTPUT_CONTROL, 16'h0011);
        wr(dtc_pkg::ADR_COMPARE_LOW, 16'h00c3);
        rd_chk("compare low", dtc_pkg::ADR_COMPARE_LOW, 16'h00c3);
        wr(dtc_pkg::ADR_COMPARE_HIGH, 16'h003c);
        rd_chk("compare high", dtc_pkg::ADR_COMPARE_HIGH, 16'h003c);
        wr(dtc_pkg::ADR_COUNT, 16'h1234);
        rd_chk("count is read only", dtc_pkg::ADR_COUNT, 16'h0000);
        wr(3'h6, 16'h00ff);
        rd_chk("unmapped index", 3'h6, 16'h0000);
        wr(dtc_pkg::ADR_OUTPUT_CONTROL, 16'h0000);
    endtask

    // every select code: legality, then divide ratio of codes 6..15 with compare zero
    task automatic t_codes;
        int div;
        int p;
        wr(dtc_pkg::ADR_MODE_CONTROL, 16'h0001);
        for (int c = 0; c < 16; c++) begin
            wr(dtc_pkg::ADR_CLOCK_SELECT, {8'h00, 4'h6, 4'(c)});
            @(negedge ref_clk);
            check("sel bad", 16'(c >= 2 && c <= 5), clockSelectBad);
        end
        wr(dtc_pkg::ADR_MODE_CONTROL, 16'h0000);
        wr(dtc_pkg::ADR_COMPARE_LOW, 16'h0000);
        for (int c = 6; c < 16; c++) begin
            div = (c == 15) ? 2048 : (2 << (c - 6));
            wr(dtc_pkg::ADR_CLOCK_SELECT, {8'h00, 4'h6, 4'(c)});
            wr(dtc_pkg::ADR_MODE_CONTROL, 16'h0001);
            period(1'b0, 2 * div + 20, p);
            check("tick period", 16'(div), 16'(p));
            wr(dtc_pkg::ADR_MODE_CONTROL, 16'h0000);
        end
    endtask

    // separate channels, both at divide by 2
    task automatic t_separate;
        int p;
        logic w;
        wr(dtc_pkg::ADR_CLOCK_SELECT, 16'h0066);
        wr(dtc_pkg::ADR_COMPARE_LOW, 16'h0003);
        wr(dtc_pkg::ADR_COMPARE_HIGH, 16'h0001);
        wr(dtc_pkg::ADR_OUTPUT_CONTROL, 16'h0011);
        wr(dtc_pkg::ADR_MODE_CONTROL, 16'h0003);
        period(1'b0, 100, p);
        check("low interval", 16'd8, 16'(p));
        w = waveOutA;
        wait_pulse(1'b0, 100, p);
        // logical not keeps the inverse one bit wide inside the cast
        check("wave A toggles", 16'(!w), 16'(waveOutA));
        period(1'b1, 100, p);
        check("high interval", 16'd4, 16'(p));
        w = waveOutB;
        wait_pulse(1'b1, 100, p);
        check("wave B toggles", 16'(!w), 16'(waveOutB));
        wr(dtc_pkg::ADR_MODE_CONTROL, 16'h0000);
    endtask

    // chained: high nibble holds a prohibited code that must be ignored
    task automatic t_cascade;
        int p;
        logic wa;
        logic wb;
        wr(dtc_pkg::ADR_CLOCK_SELECT, 16'h0026);
        wr(dtc_pkg::ADR_COMPARE_LOW, 16'h0002);
        wr(dtc_pkg::ADR_COMPARE_HIGH, 16'h0001);
        wr(dtc_pkg::ADR_MODE_CONTROL, 16'h0007);
        @(negedge ref_clk);
        check("chain select bad", 16'h0000, clockSelectBad);
        // only the high request is watched here; the low one still pulses on each low match
        period(1'b1, 1200, p);
        check("chain interval", 16'd518, 16'(p));
        wa = waveOutA;
        wb = waveOutB;
        wait_pulse(1'b0, 20, p);
        check("wave A in chain", 16'(!wa), 16'(waveOutA));
        wait_pulse(1'b1, 1200, p);
        check("wave B in chain", 16'(!wb), 16'(waveOutB));
        wr(dtc_pkg::ADR_MODE_CONTROL, 16'h0006);
        repeat (20) @(posedge ref_clk);
        rd_chk("chain stopped", dtc_pkg::ADR_COUNT, 16'h0000);
        wr(dtc_pkg::ADR_MODE_CONTROL, 16'h0000);
    endtask

    // chained event counting on both edge choices
    task automatic t_events;
        wr(dtc_pkg::ADR_CLOCK_SELECT, 16'h0001);
        wr(dtc_pkg::ADR_COMPARE_LOW, 16'h00ff);
        wr(dtc_pkg::ADR_COMPARE_HIGH, 16'h00ff);
        wr(dtc_pkg::ADR_MODE_CONTROL, 16'h0005);
        pulses(300);
        repeat (8) @(posedge ref_clk);
        rd_chk("rise cnt", dtc_pkg::ADR_COUNT, 16'h012c);
        wr(dtc_pkg::ADR_MODE_CONTROL, 16'h0000);
        wr(dtc_pkg::ADR_CLOCK_SELECT, 16'h0000);
        wr(dtc_pkg::ADR_MODE_CONTROL, 16'h0005);
        @(posedge ref_clk);
        eventInputA <= 1'b1;
        repeat (10) @(posedge ref_clk);
        rd_chk("rise ignored", dtc_pkg::ADR_COUNT, 16'h0000);
        @(posedge ref_clk);
        eventInputA <= 1'b0;
        repeat (10) @(posedge ref_clk);
        rd_chk("falling count", dtc_pkg::ADR_COUNT, 16'h0001);
    endtask

    // a frozen block must miss pin edges, since its synchroniser holds;
    // then the high channel counts pin B on its own select code
    task automatic t_freeze_pin_b;
        @(posedge ref_clk);
        ce <= 1'b0;
        eventInputA <= 1'b1;
        repeat (6) @(posedge ref_clk);
        eventInputA <= 1'b0;
        repeat (6) @(posedge ref_clk);
        ce <= 1'b1;
        repeat (10) @(posedge ref_clk);
        rd_chk("frozen count", dtc_pkg::ADR_COUNT, 16'h0001);
        wr(dtc_pkg::ADR_MODE_CONTROL, 16'h0000);
        wr(dtc_pkg::ADR_CLOCK_SELECT, 16'h0010);
        wr(dtc_pkg::ADR_MODE_CONTROL, 16'h0002);
        for (int i = 0; i < 3; i++) begin
            @(posedge ref_clk);
            eventInputB <= 1'b1;
            repeat (4) @(posedge ref_clk);
            eventInputB <= 1'b0;
            repeat (4) @(posedge ref_clk);
        end
        repeat (8) @(posedge ref_clk);
        rd_chk("pin B cnt", dtc_pkg::ADR_COUNT, 16'h0300);
        wr(dtc_pkg::ADR_MODE_CONTROL, 16'h0000);
    endtask

    // main sequence: reset held three cycles, then the scenarios
    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_regs;
        t_codes;
        t_separate;
        t_cascade;
        t_events;
        t_freeze_pin_b;
        tally_and_finish;
    end

    // watchdog: the whole run needs well under 20000 cycles
    initial begin
        repeat (60000) @(posedge ref_clk);
        fails++;
        $display("[FAIL] watchdog expected finish seen hang");
        tally_and_finish;
    end
endmodule

`default_nettype wire
